// >>> dv/dcep_enc_model.sv
// Behavioural two-track encoder with complementary lines
`timescale 1ns/100ps
module dcep_enc_model import dcep_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Motion and fault commands
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic short_i,
  // Encoder pins
  output dcep_enc_s enc_o
);
  logic [1:0] ph_r;
  // Gray phase moves one state a step, reverse when dir_i is high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ph_r <= 2'h0;
    else if (step_i) ph_r <= dir_i ? ph_r - 2'h1 : ph_r + 2'h1;
  end
  // A short ties the complement to its track, so the pair stops disagreeing
  always_comb begin
    enc_o.trk_a = ph_r[1];
    enc_o.trk_b = ph_r[1] ^ ph_r[0];
    enc_o.trk_a_n = short_i ? ph_r[1] : ~ph_r[1];
    enc_o.trk_b_n = ~enc_o.trk_b;
  end
endmodule // dcep_enc_model

// >>> dv/dcep_monitor.sv
// Checker of deviation, latching and line-fault timing at the top ports
`timescale 1ns/100ps
module dcep_monitor import dcep_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched inputs
  input wire dcep_enc_s enc_a_i,
  input wire logic [POS_W-1:0] pos_thr_i,
  input wire logic [SPD_W-1:0] spd_thr_i,
  input wire logic fault_clr_i,
  // Watched outputs
  input wire logic signed [POS_W-1:0] pos_a_o,
  input wire logic signed [POS_W-1:0] pos_b_o,
  input wire logic signed [SPD_W-1:0] spd_a_o,
  input wire logic signed [SPD_W-1:0] spd_b_o,
  input wire logic pos_dev_o,
  input wire logic spd_dev_o,
  input wire logic [1:0] enc_flt_o,
  input wire logic fault_o
);
  logic signed [POS_W:0] dp;
  logic signed [SPD_W:0] ds;
  logic pos_over;
  logic spd_over;
  logic [7:0] pair_cnt_r;
  // One bit wider so a large difference cannot wrap
  assign dp = pos_a_o - pos_b_o;
  assign ds = spd_a_o - spd_b_o;
  assign pos_over = (dp < 0 ? -dp : dp) > $signed({1'b0, pos_thr_i});
  assign spd_over = (ds < 0 ? -ds : ds) > $signed({1'b0, spd_thr_i});
  // Cycles the first pair of channel A has agreed, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) pair_cnt_r <= 8'h00;
    else if (enc_a_i.trk_a != enc_a_i.trk_a_n) pair_cnt_r <= 8'h00;
    else if (pair_cnt_r != 8'hff) pair_cnt_r <= pair_cnt_r + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence spd_moved;
    $changed(spd_a_o);
  endsequence
  sequence spd_held;
    $stable(spd_a_o) [*8];
  endsequence
  pos_dev_set_a: assert property (pos_over |=> pos_dev_o)
    else $error("position deviation not flagged");
  spd_dev_set_a: assert property (spd_over |-> ##[1:2] spd_dev_o)
    else $error("speed deviation not flagged");
  fault_or_a: assert property (
    fault_o == (pos_dev_o | spd_dev_o | (|enc_flt_o)))
    else $error("shutdown fault differs from its sources");
  pos_latch_a: assert property (pos_dev_o && !fault_clr_i |=> pos_dev_o)
    else $error("position flag dropped without clear");
  flt_latch_a: assert property (enc_flt_o[0] && !fault_clr_i |=> enc_flt_o[0])
    else $error("line fault dropped without clear");
  pos_unit_a: assert property ($changed(pos_a_o) |->
    (pos_a_o - $past(pos_a_o) == 1 || $past(pos_a_o) - pos_a_o == 1))
    else $error("position moved by more than one step");
  line_flt_a: assert property (
    pair_cnt_r == LINE_FLT_CYC + 8 |-> enc_flt_o[0])
    else $error("equal pair not flagged in time");
  spd_window_a: assert property (spd_moved |=> spd_held)
    else $error("speed changed twice within a window");
endmodule // dcep_monitor

bind dcep_top dcep_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .enc_a_i(enc_a_i), .pos_thr_i(pos_thr_i), .spd_thr_i(spd_thr_i),
  .fault_clr_i(fault_clr_i), .pos_a_o(pos_a_o), .pos_b_o(pos_b_o),
  .spd_a_o(spd_a_o), .spd_b_o(spd_b_o), .pos_dev_o(pos_dev_o),
  .spd_dev_o(spd_dev_o), .enc_flt_o(enc_flt_o), .fault_o(fault_o));

// >>> dv/dcep_top_test.sv
// Self-checking bench for the dual-channel encoder monitor
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %0d got %0d", n, e, s); end end
module dcep_top_test import dcep_pkg::*; ;
  logic clk, rst, step_a, step_b, dir, short_a, fault_clr;
  logic [POS_W-1:0] pos_thr;
  logic [SPD_W-1:0] spd_thr;
  logic [3:0] filt_sel;
  dcep_enc_s enc_a, enc_b;
  logic signed [POS_W-1:0] pos_a, pos_b;
  logic signed [SPD_W-1:0] spd_a, spd_b, accel;
  logic pos_dev, spd_dev, fault;
  logic [1:0] enc_flt;
  int fail_count, compares, cyc;

  // Short windows keep the run brief; the scale of 125 per edge stays
  dcep_top #(.WIN_CYC_P(1000), .PER_MAX_P(5000)) dut (.clk_i(clk),
    .rst_i(rst), .enc_a_i(enc_a), .enc_b_i(enc_b), .pos_thr_i(pos_thr),
    .spd_thr_i(spd_thr), .filt_sel_i(filt_sel), .fault_clr_i(fault_clr),
    .pos_a_o(pos_a), .pos_b_o(pos_b), .spd_a_o(spd_a), .spd_b_o(spd_b),
    .accel_o(accel), .pos_dev_o(pos_dev), .spd_dev_o(spd_dev),
    .enc_flt_o(enc_flt), .fault_o(fault));
  dcep_enc_model u_enc_a (.clk_i(clk), .rst_i(rst), .step_i(step_a),
    .dir_i(dir), .short_i(short_a), .enc_o(enc_a));
  dcep_enc_model u_enc_b (.clk_i(clk), .rst_i(rst), .step_i(step_b),
    .dir_i(dir), .short_i(1'b0), .enc_o(enc_b));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Steps keep gap plus two cycles apart, with a trailing wait of gap cycles
  task automatic mv(input logic a, input logic b, input logic d,
                    input int n, input int gap);
    repeat (n) begin
      @(negedge clk);
      step_a = a;
      step_b = b;
      dir = d;
      @(negedge clk);
      step_a = 1'b0;
      step_b = 1'b0;
      repeat (gap) @(negedge clk);
    end
  endtask
  task automatic clr();
    @(negedge clk);
    fault_clr = 1'b1;
    @(negedge clk);
    fault_clr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_pos();
    pos_thr = 32'h00000002;
    // One channel moving alone reads a large interval speed; keep it quiet
    spd_thr = 32'hffffffff;
    mv(1'b1, 1'b1, 1'b0, 5, 3);
    repeat (8) @(negedge clk);
    `CHK("pos_a", 5, pos_a)
    `CHK("pos_b", 5, pos_b)
    mv(1'b1, 1'b0, 1'b1, 2, 3);
    repeat (8) @(negedge clk);
    `CHK("pos_dev at limit", 1'b0, pos_dev)
    mv(1'b1, 1'b0, 1'b1, 1, 3);
    repeat (8) @(negedge clk);
    `CHK("pos_a back", 2, pos_a)
    `CHK("pos_dev over", 1'b1, pos_dev)
    `CHK("fault", 1'b1, fault)
    clr();
    `CHK("pos_dev held", 1'b1, pos_dev)
    mv(1'b0, 1'b1, 1'b1, 3, 3);
    repeat (8) @(negedge clk);
    clr();
    `CHK("pos_dev cleared", 1'b0, pos_dev)
    `CHK("fault cleared", 1'b0, fault)
    $display("position test done");
  endtask

  task automatic t_spd();
    pos_thr = 32'h0000ffff;
    spd_thr = 32'h000003e8;
    mv(1'b1, 1'b1, 1'b0, 250, 8);
    // Leftover speeds from the position test may have latched a flag
    clr();
    `CHK("spd_a edges", 100 * WIN_PER_S, spd_a)
    `CHK("spd_b edges", 100 * WIN_PER_S, spd_b)
    `CHK("spd_dev equal", 1'b0, spd_dev)
    // Channel B halts, its last interval still reads fast for a while
    mv(1'b1, 1'b0, 1'b0, 300, 8);
    `CHK("spd_dev apart", 1'b1, spd_dev)
    `CHK("fault", 1'b1, fault)
    mv(1'b1, 1'b1, 1'b0, 10, 498);
    `CHK("spd_a period", CLK_HZ / 500, spd_a)
    `CHK("spd_b period", CLK_HZ / 500, spd_b)
    clr();
    `CHK("spd_dev cleared", 1'b0, spd_dev)
    $display("speed test done");
  endtask

  task automatic t_line();
    short_a = 1'b1;
    repeat (200) @(negedge clk);
    `CHK("enc_flt", 2'h1, enc_flt)
    `CHK("fault", 1'b1, fault)
    clr();
    `CHK("enc_flt held", 2'h1, enc_flt)
    short_a = 1'b0;
    repeat (10) @(negedge clk);
    clr();
    `CHK("enc_flt cleared", 2'h0, enc_flt)
    `CHK("fault cleared", 1'b0, fault)
    $display("line test done");
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {step_a, step_b, dir, short_a, fault_clr} = 5'h00;
    pos_thr = 32'h00000002;
    spd_thr = 32'h000003e8;
    filt_sel = 4'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("fault after reset", 1'b0, fault)
    `CHK("pos after reset", 0, pos_a)
    t_pos();
    t_spd();
    t_line();
    wrap_up();
  end
endmodule // dcep_top_test

// >>> include/dcep_pkg.sv
// Shared constants and carrier types for the dual-channel encoder monitor
// Contract
// [R1] Position and speed of channel A are compared with channel B continuously.
// [R2] Absolute position difference is checked against a settable position threshold.
// [R3] Absolute speed difference is checked against a settable speed threshold.
// [R4] From 500 steps/s up count edges per window, below time the edges.
// [R5] Acceleration is derived over a window of at most 256 ms.
// [R6] Optional moving-average speed filter, 0 to 64 ms in 8 ms steps.
// [R7] Enabled filter adds its filter time to the overall response time.
// [R8] Shorts between safety-relevant encoder lines are flagged as encoder faults.
// [R9] Open or interrupted encoder lines are flagged as encoder faults.
// [R10] One or all encoder lines stuck low or high are flagged as faults.
// [R11] Any deviation or line fault sets a latched shutdown fault indication.
package dcep_pkg;

  // Clock
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_NS = 8;

  // Speed method switch point in steps per second
  localparam int unsigned FREQ_MIN_HZ = 500;

  // Edge counting window, also the filter step
  localparam int unsigned WIN_MS = 8;
  localparam int unsigned WIN_CYC = WIN_MS * (CLK_HZ / 1000);
  localparam int unsigned WIN_PER_S = 1000 / WIN_MS;

  // Acceleration window
  localparam int unsigned ACC_MS = 256;
  localparam int unsigned ACC_WINS = ACC_MS / WIN_MS;

  // Filter time range
  localparam int unsigned FILT_MAX_MS = 64;
  localparam int unsigned FILT_STEP_MS = 8;
  localparam int unsigned FILT_TAPS = FILT_MAX_MS / FILT_STEP_MS;

  // Complementary pair must disagree again within this time
  localparam int unsigned LINE_FLT_NS = 1000;
  localparam int unsigned LINE_FLT_CYC = (LINE_FLT_NS + CLK_NS - 1) / CLK_NS;

  // Longest edge interval before the axis is taken as standing still
  localparam int unsigned PER_MAX_MS = 1000;
  localparam int unsigned PER_MAX_CYC = PER_MAX_MS * (CLK_HZ / 1000);

  // Widths
  localparam int unsigned POS_W = 32;
  localparam int unsigned SPD_W = 32;

  // One encoder channel: two tracks with their complements
  typedef struct packed {
    logic trk_a;
    logic trk_a_n;
    logic trk_b;
    logic trk_b_n;
  } dcep_enc_s;

  // Results of one measuring channel
  typedef struct packed {
    logic signed [POS_W-1:0] pos;
    logic signed [SPD_W-1:0] spd;
    logic spd_vld;
    logic line_flt;
  } dcep_meas_s;

endpackage

// >>> rtl/dcep_chan.sv
// One encoder measuring channel: decode, position, speed, line diagnostics
`timescale 1ns/100ps
module dcep_chan import dcep_pkg::*; #(
  parameter int unsigned WIN_CYC_P = WIN_CYC,
  parameter int unsigned PER_MAX_P = PER_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Encoder pins
  input wire dcep_enc_s enc_i,
  // Measurement
  output dcep_meas_s meas_o
);

  logic [3:0] sync1_r, sync2_r, prev_r;
  logic [1:0] step;
  logic pair_bad;
  logic [31:0] flt_cnt_r;
  logic line_flt_r;
  logic signed [POS_W-1:0] pos_r;
  logic [31:0] win_cnt_r;
  logic signed [31:0] edge_cnt_r;
  logic signed [31:0] edge_nxt;
  logic signed [SPD_W-1:0] spd_r;
  logic spd_vld_r;
  logic [31:0] per_cnt_r;
  logic per_dir_r;
  logic div_busy_r;
  logic [5:0] div_i_r;
  logic [32:0] rem_r;
  logic [31:0] quo_r, den_r, per_spd_r;
  logic [32:0] rem_sh;
  logic [31:0] freq_mag;

  // Quadrature step: 01 forward, 11 backward, 00 none, 10 illegal
  function automatic logic [1:0] quad_step(input logic [1:0] p,
                                           input logic [1:0] n);
    case ({p, n})
      4'h1, 4'h7, 4'he, 4'h8: quad_step = 2'h1;
      4'h2, 4'hb, 4'hd, 4'h4: quad_step = 2'h3;
      4'h0, 4'h5, 4'ha, 4'hf: quad_step = 2'h0;
      default: quad_step = 2'h2;
    endcase
  endfunction

  // Two-stage synchroniser, then one stage of history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      sync1_r <= enc_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign step = quad_step({prev_r[3], prev_r[1]}, {sync2_r[3], sync2_r[1]});
  // Equal levels on a pair: open wire, short to partner or stuck line
  assign pair_bad = (sync2_r[3] == sync2_r[2]) | (sync2_r[1] == sync2_r[0]);

  // Pair must recover within LINE_FLT_CYC cycles; tolerates edge skew
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flt_cnt_r <= 32'h0;
      line_flt_r <= 1'b0;
    end else begin
      if (!pair_bad)
        flt_cnt_r <= 32'h0;
      else if (flt_cnt_r < LINE_FLT_CYC)
        flt_cnt_r <= flt_cnt_r + 32'h1;
      // Both tracks toggling at once points to shorted track lines
      line_flt_r <= (flt_cnt_r >= LINE_FLT_CYC) | (step == 2'h2); // [R8] [R9] [R10]
    end
  end

  // Position counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      pos_r <= '0;
    else if (step == 2'h1)
      pos_r <= pos_r + 32'sh1;
    else if (step == 2'h3)
      pos_r <= pos_r - 32'sh1;
  end

  // Period timer, saturates at standstill
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_cnt_r <= 32'h0;
      per_dir_r <= 1'b0;
    end else if (step[0]) begin
      per_cnt_r <= 32'h0;
      per_dir_r <= step[1];
    end else if (per_cnt_r < PER_MAX_P) begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // Serial divider: clock rate over period gives steps per second.
  // A new edge restarts it; only slow rates rely on its result.
  assign rem_sh = {rem_r[31:0], quo_r[31]};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_busy_r <= 1'b0;
      div_i_r <= 6'h0;
      rem_r <= 33'h0;
      quo_r <= 32'h0;
      den_r <= 32'h1;
      per_spd_r <= 32'h0;
    end else if (step[0]) begin
      div_busy_r <= 1'b1;
      div_i_r <= 6'h0;
      rem_r <= 33'h0;
      quo_r <= 32'(CLK_HZ);
      den_r <= per_cnt_r + 32'h1;
    end else if (div_busy_r) begin
      if (rem_sh >= {1'b0, den_r}) begin
        rem_r <= rem_sh - {1'b0, den_r};
        quo_r <= {quo_r[30:0], 1'b1};
      end else begin
        rem_r <= rem_sh;
        quo_r <= {quo_r[30:0], 1'b0};
      end
      div_i_r <= div_i_r + 6'h1;
      if (div_i_r == 6'h1f) begin
        div_busy_r <= 1'b0;
        per_spd_r <= {quo_r[30:0], rem_sh >= {1'b0, den_r}};
      end
    end else if (per_cnt_r >= PER_MAX_P) begin
      per_spd_r <= 32'h0;
    end
  end

  // Count including this cycle, so an edge on the window's last cycle
  // is not lost
  assign edge_nxt = (step == 2'h1) ? edge_cnt_r + 32'sh1 :
                    (step == 2'h3) ? edge_cnt_r - 32'sh1 : edge_cnt_r;
  assign freq_mag = 32'(edge_nxt < 0 ? -edge_nxt : edge_nxt) *
                    32'(WIN_PER_S);

  // Edge count per window; pick method at window end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_cnt_r <= 32'h0;
      edge_cnt_r <= 32'sh0;
      spd_r <= '0;
      spd_vld_r <= 1'b0;
    end else begin
      spd_vld_r <= 1'b0;
      if (win_cnt_r == WIN_CYC_P - 1) begin
        win_cnt_r <= 32'h0;
        edge_cnt_r <= 32'sh0;
        spd_vld_r <= 1'b1;
        if (freq_mag >= FREQ_MIN_HZ) // [R4]
          spd_r <= 32'(edge_nxt * $signed(32'(WIN_PER_S)));
        else if (per_dir_r)
          spd_r <= -$signed(per_spd_r); // [R4]
        else
          spd_r <= $signed(per_spd_r);
      end else begin
        win_cnt_r <= win_cnt_r + 32'h1;
        edge_cnt_r <= edge_nxt;
      end
    end
  end

  assign meas_o = '{pos: pos_r, spd: spd_r, spd_vld: spd_vld_r,
                    line_flt: line_flt_r};

endmodule // dcep_chan

// >>> rtl/dcep_top.sv
// Two-channel encoder plausibility monitor with filter and latched fault
`timescale 1ns/100ps
module dcep_top import dcep_pkg::*; #(
  parameter int unsigned WIN_CYC_P = WIN_CYC,
  parameter int unsigned PER_MAX_P = PER_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Encoder channels
  input wire dcep_enc_s enc_a_i,
  input wire dcep_enc_s enc_b_i,
  // Configuration levels
  input wire logic [POS_W-1:0] pos_thr_i,
  input wire logic [SPD_W-1:0] spd_thr_i,
  input wire logic [3:0] filt_sel_i,
  input wire logic fault_clr_i,
  // Measured values
  output logic signed [POS_W-1:0] pos_a_o,
  output logic signed [POS_W-1:0] pos_b_o,
  output logic signed [SPD_W-1:0] spd_a_o,
  output logic signed [SPD_W-1:0] spd_b_o,
  output logic signed [SPD_W-1:0] accel_o,
  // Fault indications
  output logic pos_dev_o,
  output logic spd_dev_o,
  output logic [1:0] enc_flt_o,
  output logic fault_o
);

  typedef logic signed [SPD_W-1:0] dcep_hist_t [FILT_TAPS];

  dcep_meas_s meas_a, meas_b;
  dcep_hist_t hist_a_r, hist_b_r;
  logic tick_d_r;
  logic [3:0] taps_r;
  logic signed [SPD_W-1:0] filt_a_r, filt_b_r, spd_old_r, accel_r;
  logic [7:0] acc_cnt_r;
  logic signed [POS_W-1:0] pos_a_r, pos_b_r;
  logic pos_dev_r, spd_dev_r, fault_r;
  logic [1:0] enc_flt_r;
  logic pos_over, spd_over;
  logic signed [POS_W:0] pos_diff;
  logic signed [SPD_W:0] spd_diff;
  logic [POS_W:0] pos_mag;
  logic [SPD_W:0] spd_mag;

  // Mean of the newest k window speeds; k of zero passes the raw value
  function automatic logic signed [SPD_W-1:0] mean_of(input dcep_hist_t h,
                                                      input logic [3:0] k);
    longint sum;
    longint recip;
    sum = 0;
    recip = 0;
    for (int i = 0; i < FILT_TAPS; i++) begin
      if (i < int'(k))
        sum = sum + longint'(h[i]);
    end
    if (k == 4'h0) begin
      mean_of = h[0];
    end else begin
      recip = (longint'(65536) + longint'(k) / 2) / longint'(k);
      mean_of = SPD_W'((sum * recip) >>> 16);
    end
  endfunction

  // Absolute value of a signed difference, one bit wider than operands
  function automatic logic [POS_W:0] mag_of(input logic signed [POS_W:0] d);
    mag_of = d < 0 ? (POS_W+1)'(-d) : (POS_W+1)'(d);
  endfunction

  // Measuring channel A
  dcep_chan #(
    .WIN_CYC_P(WIN_CYC_P),
    .PER_MAX_P(PER_MAX_P)
  ) u_chan_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enc_i(enc_a_i),
    .meas_o(meas_a)
  );

  // Measuring channel B, same window timing as A
  dcep_chan #(
    .WIN_CYC_P(WIN_CYC_P),
    .PER_MAX_P(PER_MAX_P)
  ) u_chan_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enc_i(enc_b_i),
    .meas_o(meas_b)
  );

  // Filter length in windows, clamped to the longest setting
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      taps_r <= 4'h0;
    else if (filt_sel_i > 4'(FILT_TAPS))
      taps_r <= 4'(FILT_TAPS); // [R6]
    else
      taps_r <= filt_sel_i; // [R6]
  end

  // Speed history, one entry per window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < FILT_TAPS; i++) begin
        hist_a_r[i] <= '0;
        hist_b_r[i] <= '0;
      end
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= meas_a.spd_vld;
      if (meas_a.spd_vld) begin
        hist_a_r[0] <= meas_a.spd;
        hist_b_r[0] <= meas_b.spd;
        for (int i = 1; i < FILT_TAPS; i++) begin
          hist_a_r[i] <= hist_a_r[i-1];
          hist_b_r[i] <= hist_b_r[i-1];
        end
      end
    end
  end

  // Averaging delays speed by up to the filter time, which adds to
  // the monitor's reaction time; that is the price of smoothing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_a_r <= '0;
      filt_b_r <= '0;
    end else if (tick_d_r) begin
      filt_a_r <= mean_of(hist_a_r, taps_r); // [R6] [R7]
      filt_b_r <= mean_of(hist_b_r, taps_r); // [R7]
    end
  end

  // Acceleration over a fixed window from filtered speed of channel A
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_cnt_r <= 8'h0;
      spd_old_r <= '0;
      accel_r <= '0;
    end else if (tick_d_r) begin
      if (acc_cnt_r == 8'(ACC_WINS - 1)) begin
        acc_cnt_r <= 8'h0;
        spd_old_r <= filt_a_r;
        // Steps per second per second: delta times 1000 over window ms
        accel_r <= SPD_W'(((longint'(filt_a_r) - longint'(spd_old_r)) *
                   1000) / longint'(ACC_MS)); // [R5]
      end else begin
        acc_cnt_r <= acc_cnt_r + 8'h1;
      end
    end
  end

  // Registered copies of position
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_a_r <= '0;
      pos_b_r <= '0;
    end else begin
      pos_a_r <= meas_a.pos;
      pos_b_r <= meas_b.pos;
    end
  end

  // Cross comparison, wide enough that wrapped differences stay exact
  assign pos_diff = (POS_W+1)'(pos_a_r) - (POS_W+1)'(pos_b_r); // [R1]
  assign spd_diff = (SPD_W+1)'(filt_a_r) - (SPD_W+1)'(filt_b_r); // [R1]
  assign pos_mag = mag_of(pos_diff);
  assign spd_mag = mag_of(spd_diff);
  assign pos_over = pos_mag > {1'b0, pos_thr_i}; // [R2]
  assign spd_over = spd_mag > {1'b0, spd_thr_i}; // [R3]

  // Latched flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_dev_r <= 1'b0;
      spd_dev_r <= 1'b0;
      enc_flt_r <= 2'h0;
      fault_r <= 1'b0;
    end else begin
      pos_dev_r <= (pos_dev_r & ~fault_clr_i) | pos_over; // [R2]
      spd_dev_r <= (spd_dev_r & ~fault_clr_i) | spd_over; // [R3]
      enc_flt_r <= (enc_flt_r & {2{~fault_clr_i}}) |
                   {meas_b.line_flt, meas_a.line_flt}; // [R8] [R9] [R10]
      fault_r <= (fault_r & ~fault_clr_i) | pos_over | spd_over |
                 meas_a.line_flt | meas_b.line_flt; // [R11]
    end
  end

  // Outputs straight from flops
  assign pos_a_o = pos_a_r;
  assign pos_b_o = pos_b_r;
  assign spd_a_o = filt_a_r;
  assign spd_b_o = filt_b_r;
  assign accel_o = accel_r;
  assign pos_dev_o = pos_dev_r;
  assign spd_dev_o = spd_dev_r;
  assign enc_flt_o = enc_flt_r;
  assign fault_o = fault_r;

endmodule // dcep_top
